// ---- design/nsr_pkg.sv ----
// Purpose: Shared constants and types for the persistent register save/restore block.
// Assumes: Clause 45 style management frames; 16-bit registers.
// Notes: All offsets, field positions, reset values and codes are named here once.

package nsr_pkg;

  // ********************************************************************
  // Register map and field layout.
  // ********************************************************************
  localparam logic [15:0] NSR_ADDR_ACCESS_CTRL = 16'ha004;
  localparam logic [15:0] NSR_PAGE_PERSIST = 16'h8000;
  localparam logic [15:0] NSR_PAGE_VOLATILE = 16'ha000;
  localparam int NSR_CTRL_VEND_LSB = 9;
  localparam int NSR_CTRL_CMD_BIT = 5;
  localparam int NSR_CTRL_STAT_LSB = 2;
  localparam int NSR_CTRL_EXT_LSB = 0;
  localparam logic [15:0] NSR_CTRL_RESET = 16'h0000;
  localparam logic [15:0] NSR_SHADOW_RESET = 16'h0000;

  // ********************************************************************
  // Command status and qualifier codes.
  // ********************************************************************
  localparam logic [1:0] NSR_STAT_IDLE = 2'h0;
  localparam logic [1:0] NSR_STAT_OK = 2'h1;
  localparam logic [1:0] NSR_STAT_BUSY = 2'h2;
  localparam logic [1:0] NSR_STAT_FAIL = 2'h3;
  localparam logic [1:0] NSR_EXT_ALL = 2'h3;

  // ********************************************************************
  // Management frame constants.
  // ********************************************************************
  localparam logic [5:0] NSR_PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] NSR_HDR_LAST = 5'h0d;
  localparam logic [4:0] NSR_DATA_LAST = 5'h0f;
  localparam logic [1:0] NSR_ST_C45 = 2'h0;
  localparam logic [1:0] NSR_OP_ADDR = 2'h0;
  localparam logic [1:0] NSR_OP_WRITE = 2'h1;
  localparam logic [1:0] NSR_OP_READ_INC = 2'h2;
  localparam logic [1:0] NSR_OP_READ = 2'h3;

  // Least number of saves the persistent store must be rated for.
  localparam int NSR_SAVE_ENDURANCE_MIN = 10000;

  // ********************************************************************
  // Types.
  // ********************************************************************
  typedef enum logic [1:0] {NSR_C_IDLE, NSR_C_PEND, NSR_C_EXEC, NSR_C_DONE} nsr_cmd_st_t;
  typedef enum logic [1:0] {NSR_M_PRE, NSR_M_HDR, NSR_M_TA, NSR_M_DATA} nsr_mdio_st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } nsr_pm_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } nsr_pm_rsp_t;

  typedef struct packed {
    nsr_cmd_st_t st;
    logic boot;
    logic save;
    logic fail;
    logic [1:0] ext;
    logic [6:0] vend;
    logic [7:0] idx;
    nsr_pm_req_t pm;
    logic soft_rst;
  } nsr_ctl_t;

  typedef struct packed {
    nsr_mdio_st_t st;
    logic mdc_q;
    logic [5:0] cnt;
    logic [15:0] sr;
    logic [1:0] op;
    logic hit;
    logic [15:0] addr;
    logic mdo;
    logic mdoe;
  } nsr_mdio_t;

endpackage : nsr_pkg

// ---- design/nsr_save_restore.sv ----
// Purpose: Persistent register shadow file with save/restore command machine behind a management port.
// Assumes: i_mdc and i_mdio_i are synchronous to i_clk and far slower than it.
// Notes: Shadow words sit at the persistent page; the access control word sits on the volatile page.
//
// Behaviour
// - Host reads RO, RW and clear-on-read registers.
// - Writes to persistent registers change shadow only.
// - All access goes through management frames directly.
// - One save copies every shadow word out.
// - Persistent store rated above ten thousand saves.
// - Reset reloads all shadow words from store.
// - Restore overwrites every shadow word from store.
// - Bit 5 selects restore zero, save one.
// - Bits 3:2 report idle, ok, busy, failed.
// - Bits 1:0 qualify; 11b means all words.
// - Command and qualifier held until back idle.
// - Control writes count only while status idle.
// - Reading control after completion returns to idle.
// - Idle control write launches selected operation.
// - One command at once; busy ignores control writes.
// - Soft reset waits until command finishes.
// - Idle, pending, executing, complete; busy shows 10b.
// - Saves during reset or initialize are refused.

`timescale 1ns/1ps

module nsr_save_restore #(
  parameter int NV_WORDS = 16,
  parameter logic [4:0] PORT_ADDR = 5'h00,
  parameter logic [4:0] DEV_ADDR = 5'h01,
  parameter int PM_ENDURANCE = 100000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_mdc,
  input wire logic i_mdio_i,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic i_module_init,
  input wire logic i_soft_reset_req,
  output logic o_soft_reset,
  input wire logic i_pm_ready,
  output nsr_pkg::nsr_pm_req_t o_pm,
  input wire nsr_pkg::nsr_pm_rsp_t i_pm
);
  import nsr_pkg::*;

  // ********************************************************************
  // Elaboration checks.
  // ********************************************************************
  // The word index is eight bits wide and the store must outlast the saves.
  if (NV_WORDS < 1 || NV_WORDS > 256)
  begin : g_bad_words
    $error("NV_WORDS must lie between 1 and 256.");
  end
  if (PM_ENDURANCE <= NSR_SAVE_ENDURANCE_MIN)
  begin : g_bad_endurance
    $error("PM_ENDURANCE must exceed the least save count.");
  end

  // ********************************************************************
  // State.
  // ********************************************************************
  typedef struct packed {
    nsr_ctl_t ctl;
    nsr_mdio_t mdio;
    logic [NV_WORDS-1:0][15:0] shadow;
  } nsr_state_t;

  localparam logic [7:0] LAST_IDX = 8'(NV_WORDS - 1);
  localparam logic [15:0] NV_SPAN = 16'(NV_WORDS);

  nsr_state_t q_r;
  nsr_state_t q_nxt;

  // ********************************************************************
  // Next-state logic.
  // ********************************************************************
  // Command machine first, then the frame engine that may override it.
  always_comb
  begin
    logic edge_seen;
    logic bit_in;
    logic [13:0] hdr;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [15:0] rel;
    logic [7:0] widx;
    logic in_nv;
    logic [1:0] status;
    edge_seen = 1'b0;
    bit_in = 1'b0;
    hdr = '0;
    wr_word = '0;
    rd_word = '0;
    rel = '0;
    widx = '0;
    in_nv = 1'b0;
    status = NSR_STAT_IDLE;
    q_nxt = q_r;

    // Status follows the command machine state.
    unique case (q_r.ctl.st)
      NSR_C_IDLE: status = NSR_STAT_IDLE;
      NSR_C_PEND: status = NSR_STAT_BUSY;
      NSR_C_EXEC: status = NSR_STAT_BUSY;
      NSR_C_DONE: status = q_r.ctl.fail ? NSR_STAT_FAIL : NSR_STAT_OK;
    endcase

    // Pending waits for the store to be free; executing walks every word.
    unique case (q_r.ctl.st)
      NSR_C_IDLE:
      begin
      end
      NSR_C_PEND:
      begin
        if (i_pm_ready)
        begin
          q_nxt.ctl.idx = '0;
          q_nxt.ctl.fail = 1'b0;
          if (!q_r.ctl.boot && q_r.ctl.ext != NSR_EXT_ALL)
          begin
            // Vendor-specific qualifiers are not served here and report failure.
            q_nxt.ctl.fail = 1'b1;
            q_nxt.ctl.st = NSR_C_DONE;
          end
          else
          begin
            q_nxt.ctl.st = NSR_C_EXEC;
          end
        end
      end
      NSR_C_EXEC:
      begin
        if (!q_r.ctl.pm.req)
        begin
          // Boot loads always restore; a save writes the shadow word out.
          q_nxt.ctl.pm.req = 1'b1;
          q_nxt.ctl.pm.we = q_r.ctl.save && !q_r.ctl.boot;
          q_nxt.ctl.pm.addr = q_r.ctl.idx;
          q_nxt.ctl.pm.wdata = q_r.shadow[q_r.ctl.idx];
        end
        else if (i_pm.ack)
        begin
          q_nxt.ctl.pm.req = 1'b0;
          if (!q_r.ctl.pm.we)
          begin
            q_nxt.shadow[q_r.ctl.idx] = i_pm.rdata;
          end
          if (i_pm.err || q_r.ctl.idx == LAST_IDX)
          begin
            q_nxt.ctl.fail = i_pm.err;
            q_nxt.ctl.boot = 1'b0;
            q_nxt.ctl.st = q_r.ctl.boot ? NSR_C_IDLE : NSR_C_DONE;
          end
          else
          begin
            q_nxt.ctl.idx = q_r.ctl.idx + 8'h01;
          end
        end
      end
      NSR_C_DONE:
      begin
      end
    endcase

    // A soft reset is passed on only when no command is running.
    q_nxt.ctl.soft_rst = i_soft_reset_req && (q_r.ctl.st == NSR_C_IDLE || q_r.ctl.st == NSR_C_DONE);

    // Frame engine: sample the data pin on each rising management clock.
    q_nxt.mdio.mdc_q = i_mdc;
    edge_seen = i_mdc && !q_r.mdio.mdc_q;
    bit_in = i_mdio_i;
    rel = q_r.mdio.addr - NSR_PAGE_PERSIST;
    in_nv = (q_r.mdio.addr >= NSR_PAGE_PERSIST) && (rel < NV_SPAN);
    widx = rel[7:0];
    hdr = {q_r.mdio.sr[12:0], bit_in};
    wr_word = {q_r.mdio.sr[14:0], bit_in};

    // Read value of the addressed register; unmapped words read zero.
    if (q_r.mdio.addr == NSR_ADDR_ACCESS_CTRL)
    begin
      rd_word = NSR_CTRL_RESET;
      rd_word[NSR_CTRL_VEND_LSB +: 7] = q_r.ctl.vend;
      rd_word[NSR_CTRL_CMD_BIT] = q_r.ctl.save;
      rd_word[NSR_CTRL_STAT_LSB +: 2] = status;
      rd_word[NSR_CTRL_EXT_LSB +: 2] = q_r.ctl.ext;
    end
    else if (in_nv)
    begin
      rd_word = q_r.shadow[widx];
    end

    if (edge_seen)
    begin
      unique case (q_r.mdio.st)
        NSR_M_PRE:
        begin
          // Count ones; the first zero after a full preamble opens the header.
          if (bit_in)
          begin
            if (q_r.mdio.cnt != NSR_PREAMBLE_BITS)
            begin
              q_nxt.mdio.cnt = q_r.mdio.cnt + 6'h01;
            end
          end
          else if (q_r.mdio.cnt == NSR_PREAMBLE_BITS)
          begin
            q_nxt.mdio.st = NSR_M_HDR;
            q_nxt.mdio.sr = '0;
            q_nxt.mdio.cnt = 6'h01;
          end
          else
          begin
            q_nxt.mdio.cnt = '0;
          end
        end
        NSR_M_HDR:
        begin
          q_nxt.mdio.sr = wr_word;
          q_nxt.mdio.cnt = q_r.mdio.cnt + 6'h01;
          if (q_r.mdio.cnt[4:0] == NSR_HDR_LAST)
          begin
            q_nxt.mdio.st = NSR_M_TA;
            q_nxt.mdio.cnt = '0;
            q_nxt.mdio.op = hdr[11:10];
            q_nxt.mdio.hit = hdr[13:12] == NSR_ST_C45 && hdr[9:5] == PORT_ADDR && hdr[4:0] == DEV_ADDR;
            if (q_nxt.mdio.hit && hdr[11] == 1'b1)
            begin
              // Capture read data now; reading a finished command returns it to idle.
              q_nxt.mdio.sr = rd_word;
              if (q_r.mdio.addr == NSR_ADDR_ACCESS_CTRL && q_r.ctl.st == NSR_C_DONE)
              begin
                q_nxt.ctl.st = NSR_C_IDLE;
              end
              if (hdr[11:10] == NSR_OP_READ_INC)
              begin
                q_nxt.mdio.addr = q_r.mdio.addr + 16'h0001;
              end
            end
          end
        end
        NSR_M_TA:
        begin
          q_nxt.mdio.cnt = q_r.mdio.cnt + 6'h01;
          if (q_r.mdio.hit && q_r.mdio.op[1])
          begin
            // Drive zero for the second turnaround bit, then the data MSB.
            q_nxt.mdio.mdoe = 1'b1;
            q_nxt.mdio.mdo = (q_r.mdio.cnt == '0) ? 1'b0 : q_r.mdio.sr[15];
            if (q_r.mdio.cnt != '0)
            begin
              q_nxt.mdio.sr = {q_r.mdio.sr[14:0], 1'b0};
            end
          end
          if (q_r.mdio.cnt != '0)
          begin
            q_nxt.mdio.st = NSR_M_DATA;
            q_nxt.mdio.cnt = '0;
          end
        end
        NSR_M_DATA:
        begin
          q_nxt.mdio.cnt = q_r.mdio.cnt + 6'h01;
          if (q_r.mdio.hit && q_r.mdio.op[1])
          begin
            q_nxt.mdio.mdo = q_r.mdio.sr[15];
            q_nxt.mdio.sr = {q_r.mdio.sr[14:0], 1'b0};
          end
          else
          begin
            q_nxt.mdio.sr = wr_word;
          end
          if (q_r.mdio.cnt[4:0] == NSR_DATA_LAST)
          begin
            q_nxt.mdio.st = NSR_M_PRE;
            q_nxt.mdio.cnt = '0;
            q_nxt.mdio.mdoe = 1'b0;
            q_nxt.mdio.mdo = 1'b0;
            if (q_r.mdio.hit && q_r.mdio.op == NSR_OP_ADDR)
            begin
              q_nxt.mdio.addr = wr_word;
            end
            if (q_r.mdio.hit && q_r.mdio.op == NSR_OP_WRITE)
            begin
              if (q_r.mdio.addr == NSR_ADDR_ACCESS_CTRL)
              begin
                // Only an idle machine outside reset or initialize takes a command.
                if (q_r.ctl.st == NSR_C_IDLE && !i_module_init)
                begin
                  q_nxt.ctl.st = NSR_C_PEND;
                  q_nxt.ctl.save = wr_word[NSR_CTRL_CMD_BIT];
                  q_nxt.ctl.ext = wr_word[NSR_CTRL_EXT_LSB +: 2];
                  q_nxt.ctl.vend = wr_word[NSR_CTRL_VEND_LSB +: 7];
                end
              end
              else if (in_nv && q_r.ctl.st != NSR_C_EXEC)
              begin
                // Host edits land in the shadow; the store is untouched.
                q_nxt.shadow[widx] = wr_word;
              end
            end
          end
        end
      endcase
    end
  end

  // ********************************************************************
  // State register.
  // ********************************************************************
  // Reset starts a boot restore of the whole shadow file.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      q_r <= '0;
      q_r.ctl.st <= NSR_C_PEND;
      q_r.ctl.boot <= 1'b1;
      q_r.shadow <= {NV_WORDS{NSR_SHADOW_RESET}};
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ********************************************************************
  // Outputs.
  // ********************************************************************
  // All outputs come straight from the state register.
  assign o_mdio_o = q_r.mdio.mdo;
  assign o_mdio_oe = q_r.mdio.mdoe;
  assign o_soft_reset = q_r.ctl.soft_rst;
  assign o_pm = q_r.ctl.pm;

endmodule : nsr_save_restore

// ---- verification/nsr_assertions.sv ----
// Purpose: Port-level checks of the save/restore block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module nsr_assertions #(
  parameter int NV_WORDS = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_reset_req,
  input wire logic o_soft_reset,
  input wire logic o_mdio_o,
  input wire logic o_mdio_oe,
  input wire nsr_pkg::nsr_pm_req_t o_pm,
  input wire nsr_pkg::nsr_pm_rsp_t i_pm
);
  import nsr_pkg::*;
  // ********************
  // Store port, soft reset and turnaround checks.
  // ********************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // A word completes when its request meets an acknowledge.
  sequence s_ack;
    o_pm.req && i_pm.ack;
  endsequence
  sequence s_next;
    s_ack ##2 o_pm.req;
  endsequence
  AST_REQ_HOLD: assert property (o_pm.req && !i_pm.ack |=> o_pm.req && $stable(o_pm))
    else $error("store request changed before ack");
  AST_REQ_DROP: assert property (s_ack |=> !o_pm.req)
    else $error("store request held after ack");
  AST_ADDR_STEP: assert property (s_next |-> o_pm.addr == $past(o_pm.addr, 2) + 8'h01)
    else $error("store word index did not step by one");
  AST_WE_SAME: assert property (s_next |-> o_pm.we == $past(o_pm.we, 2))
    else $error("store direction changed inside a command");
  AST_FIRST_ZERO: assert property ($rose(o_pm.req) && !$past(i_pm.ack, 2) |-> o_pm.addr == 8'h00)
    else $error("command did not start at word zero");
  AST_ADDR_RANGE: assert property (o_pm.req |-> {24'h0, o_pm.addr} < NV_WORDS)
    else $error("store word index out of range");
  AST_ERR_STOP: assert property (s_ack ##0 i_pm.err |=> !o_pm.req [*4])
    else $error("store access went on after an error");
  AST_SOFT_HOLD: assert property (o_pm.req |-> !o_soft_reset)
    else $error("soft reset passed during a command");
  AST_SOFT_CAUSE: assert property ($rose(o_soft_reset) |-> $past(i_soft_reset_req))
    else $error("soft reset rose without a request");
  AST_SOFT_OFF: assert property (!i_soft_reset_req |=> !o_soft_reset)
    else $error("soft reset stayed high without a request");
  AST_TA_ZERO: assert property ($rose(o_mdio_oe) |-> !o_mdio_o)
    else $error("turnaround bit not driven low");
endmodule : nsr_assertions

bind nsr_save_restore nsr_assertions #(.NV_WORDS(NV_WORDS)) u_chk (.i_clk, .i_rst_n, .i_soft_reset_req,
  .o_soft_reset, .o_mdio_o, .o_mdio_oe, .o_pm, .i_pm);

// ---- verification/nsr_pm_model.sv ----
// Purpose: Behavioural persistent store facing the block.
// Assumes: One request at a time, answered after i_delay cycles.
// Notes: i_err_at names a word whose access fails; 9'h1ff never fails.
`timescale 1ns/1ps
module nsr_pm_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire nsr_pkg::nsr_pm_req_t i_req,
  input wire logic [3:0] i_delay,
  input wire logic [8:0] i_err_at,
  output nsr_pkg::nsr_pm_rsp_t o_rsp
);
  import nsr_pkg::*;
  logic [15:0] mem [256];
  logic [3:0] wait_r = 4'h0;
  int save_cnt = 0;
  initial o_rsp = '0;
  // ********************
  // Store behaviour.
  // ********************
  // Answers each request with a one-cycle acknowledge; idle data lines toggle.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rsp.ack <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (i_req.req && !o_rsp.ack && wait_r >= i_delay)
    begin
      o_rsp.ack <= 1'b1;
      o_rsp.err <= {1'b0, i_req.addr} == i_err_at;
      o_rsp.rdata <= mem[i_req.addr];
      if (i_req.we && {1'b0, i_req.addr} != i_err_at)
        mem[i_req.addr] <= i_req.wdata;
      if (i_req.we && i_req.addr == 8'h00)
        save_cnt <= save_cnt + 1;
      wait_r <= 4'h0;
    end
    else
    begin
      o_rsp.ack <= 1'b0;
      o_rsp.err <= ~o_rsp.err;
      o_rsp.rdata <= ~o_rsp.rdata;
      wait_r <= (i_req.req && !o_rsp.ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : nsr_pm_model

// ---- verification/nsr_tb.sv ----
// Purpose: Self-checking bench for the save/restore block.
// Assumes: Host frames built here, store answered by the model.
// Notes: Shadow and store contents are tracked in integer arrays.
`timescale 1ns/1ps
module tb;
  import nsr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_mdc = 1'b0;
  logic i_mdio_i = 1'b1;
  logic i_module_init = 1'b0;
  logic i_soft_reset_req = 1'b0;
  logic i_pm_ready = 1'b0;
  logic o_mdio_o, o_mdio_oe, o_soft_reset;
  nsr_pm_req_t o_pm;
  nsr_pm_rsp_t i_pm;
  logic [3:0] pm_delay = 4'h0;
  logic [8:0] err_at = 9'h1ff;
  logic [15:0] q, c;
  int failures = 0;
  int cmp_count = 0;
  int seed = 32'h50b2;
  int nv [16];
  int sh [16];
  localparam logic [15:0] CTL = NSR_ADDR_ACCESS_CTRL;
  always #2 i_clk = ~i_clk;
  nsr_save_restore dut (.i_clk, .i_rst_n, .i_mdc, .i_mdio_i, .o_mdio_o, .o_mdio_oe, .i_module_init,
    .i_soft_reset_req, .o_soft_reset, .i_pm_ready, .o_pm, .i_pm);
  nsr_pm_model pm (.i_clk, .i_rst_n, .i_req(o_pm), .i_delay(pm_delay), .i_err_at(err_at), .o_rsp(i_pm));
  // ********************
  // Host frame tasks.
  // ********************
  // One frame; the host lets the data line float high while the block answers.
  task automatic frame(input logic [1:0] op, input logic [15:0] d);
    logic [63:0] v;
    v = {32'hffffffff, NSR_ST_C45, op, 5'h00, 5'h01, op[1] ? 2'h3 : 2'h2, op[1] ? 16'hffff : d};
    for (int i = 63; i >= 0; i--)
    begin
      @(negedge i_clk) i_mdio_i = v[i];
      @(negedge i_clk);
      if (i < 16)
        q[i] = o_mdio_o;
      i_mdc = 1'b1;
      repeat (2) @(negedge i_clk);
      i_mdc = 1'b0;
    end
  endtask : frame
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    frame(NSR_OP_ADDR, a);
    frame(NSR_OP_WRITE, d);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    frame(NSR_OP_ADDR, a);
    frame(NSR_OP_READ, 16'h0);
  endtask : rd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Reads control until it leaves busy; the final read also returns it to idle.
  task automatic poll();
    int n;
    n = 0;
    rd(CTL);
    while (q[3:2] === NSR_STAT_BUSY && n < 40)
    begin
      frame(NSR_OP_READ, 16'h0);
      n++;
    end
  endtask : poll
  task automatic cmp_mem();
    frame(NSR_OP_ADDR, NSR_PAGE_PERSIST);
    for (int i = 0; i < 16; i++)
    begin
      frame(NSR_OP_READ_INC, 16'h0);
      chk(q, sh[i][15:0]);
      chk(pm.mem[i], nv[i][15:0]);
    end
  endtask : cmp_mem
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge i_clk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  // ********************
  // Test sequence.
  // ********************
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      nv[i] = $random(seed) & 32'hffff;
      pm.mem[i] = nv[i][15:0];
      sh[i] = nv[i];
    end
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    wr(CTL, 16'h0023);
    rd(CTL);
    chk(q, 16'h0008);
    i_pm_ready = 1'b1;
    pm_delay = 4'($random(seed) & 3);
    poll();
    chk(q, 16'h0000);
    cmp_mem();
    $display("test boot done");
    i_pm_ready = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      sh[i] = $random(seed) & 32'hffff;
      wr(NSR_PAGE_PERSIST + 16'(i), sh[i][15:0]);
    end
    cmp_mem();
    i_soft_reset_req = 1'b1;
    wr(CTL, 16'h0023);
    rd(CTL);
    chk(q, 16'h002b);
    wr(CTL, 16'h0001);
    rd(CTL);
    chk(q, 16'h002b);
    chk({15'h0, o_soft_reset}, 16'h0000);
    i_pm_ready = 1'b1;
    poll();
    chk(q, 16'h0027);
    rd(CTL);
    chk(q, 16'h0023);
    chk({15'h0, o_soft_reset}, 16'h0001);
    i_soft_reset_req = 1'b0;
    nv = sh;
    cmp_mem();
    $display("test save done");
    for (int i = 0; i < 16; i++)
      wr(NSR_PAGE_PERSIST + 16'(i), 16'(~sh[i]));
    wr(CTL, 16'hfe03);
    poll();
    chk(q, 16'hfe07);
    cmp_mem();
    $display("test restore done");
    for (int k = 0; k < 6; k++)
    begin
      c = 16'((k / 3) * 32 + k % 3);
      wr(CTL, c);
      poll();
      chk(q, c | 16'h000c);
    end
    $display("test vendor done");
    err_at = 9'(1 + ($random(seed) & 7));
    sh[0] = $random(seed) & 32'hffff;
    sh[15] = $random(seed) & 32'hffff;
    wr(NSR_PAGE_PERSIST, sh[0][15:0]);
    wr(NSR_PAGE_PERSIST + 16'h000f, sh[15][15:0]);
    wr(CTL, 16'h0023);
    poll();
    chk(q, 16'h002f);
    for (int i = 0; i < 16; i++)
      if (i < err_at)
        nv[i] = sh[i];
    err_at = 9'h1ff;
    cmp_mem();
    chk(16'(pm.save_cnt), 16'h0002);
    $display("test error done");
    i_module_init = 1'b1;
    wr(CTL, 16'h0023);
    rd(CTL);
    chk(q, 16'h0023);
    i_module_init = 1'b0;
    wr(16'h8010, 16'h1234);
    rd(16'h8010);
    chk(q, 16'h0000);
    chk({15'h0, o_mdio_oe}, 16'h0000);
    $display("test refuse done");
    // Shadow words 3 and 15 differ from the store when the hardware reset comes.
    wr(NSR_PAGE_PERSIST + 16'h0003, 16'(~nv[3]));
    rd(CTL);
    chk({14'h0, q[3:2]}, {14'h0, NSR_STAT_IDLE});
    @(negedge i_clk) i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(CTL);
    chk(q, NSR_CTRL_RESET);
    sh = nv;
    cmp_mem();
    $display("test reset done");
    finish_test();
  end
endmodule : tb
